// [verilog/wdsw_top.sv]
// Watchdog with configuration switch input register, Avalon-MM slave
//
// The Avalon-MM slave port was decided locally.
`timescale 1ns/1ns
`include "wdsw_defs.svh"
module wdsw_top #(
    parameter int TICK_CYC = `WDSW_TICK_CYC,
    parameter int RST_CYC  = `WDSW_RST_CYC,
    parameter int NMI_CYC  = `WDSW_NMI_CYC
) (
    input  wire logic                      clk_sys,
    input  wire logic                      reset_n,
    input  wire logic [`WDSW_ADDR_W-1:0]   avs_address,
    input  wire logic                      avs_read,
    input  wire logic                      avs_write,
    input  wire logic [31:0]               avs_writedata,
    input  wire logic [3:0]                avs_byteenable,
    output logic      [31:0]               avs_readdata,
    output logic                           avs_waitrequest,
    input  wire logic [`WDSW_SW_W-1:0]     config_switch,
    output logic                           sys_reset_out,
    output logic                           nmi_out,
    output logic                           irq
);
    import wdsw_pkg::*;

    localparam int PW = `WDSW_PULSE_W;
    localparam int MW = `WDSW_MS_W;

    if (RST_CYC < 1 || NMI_CYC < 1 || RST_CYC >= 2 ** PW || NMI_CYC >= 2 ** PW) begin : g_chk
        $error("wdsw_top: pulse lengths must fit the pulse counter");
    end

    logic                  waitrequest_reg;
    logic                  waitrequest_next;
    logic [31:0]           readdata_reg;
    logic [31:0]           readdata_next;
    wdsw_ctrl_s            ctrl_reg;
    wdsw_ctrl_s            ctrl_next;
    wdsw_ctrl_s            wr_ctrl_val;
    logic                  flag_reg;
    logic                  flag_next;
    logic                  en_prev_reg;
    logic [PW-1:0]         pulse_cnt_reg;
    logic [PW-1:0]         pulse_cnt_next;
    wdsw_action_e          pulse_kind_reg;
    wdsw_action_e          pulse_kind_next;
    logic                  sys_reset_reg;
    logic                  sys_reset_next;
    logic                  nmi_reg;
    logic                  nmi_next;
    wdsw_irq_s             irq_stat_reg;
    wdsw_irq_s             irq_stat_next;
    wdsw_irq_s             irq_mask_reg;
    wdsw_irq_s             irq_mask_next;
    logic                  irq_reg;
    logic                  irq_next;
    logic [`WDSW_SW_W-1:0] sw_q;
    logic [MW-1:0]         limit_ms;
    logic                  expire;
    logic                  req;
    logic                  acc;
    logic                  wr;
    logic [7:0]            wr_data;
    logic                  wr_ctrl;
    logic                  wr_opt;
    logic                  wr_sw;
    logic                  kick;
    logic                  refused;
    logic                  idle;
    logic                  en_rise;
    logic                  fire;
    logic                  hw_key;
    logic                  start_rst;

    // Switch pins come from outside the clock domain
    wdsw_sync #(
        .W (`WDSW_SW_W)
    ) u_sync (
        .clk_sys (clk_sys),
        .reset_n (reset_n),
        .din     (config_switch),
        .dout    (sw_q)
    );

    // Period select: 0 depends on switch bit 0, others double from 4 s
    always_comb begin
        if (ctrl_reg.wdog_period_select == 3'h0) begin
            limit_ms = sw_q[0] ? MW'(`WDSW_TO_SHORT_MS) : MW'(`WDSW_TO_BASE_MS);
        end else begin
            limit_ms = MW'(`WDSW_TO_STEP_MS) << ctrl_reg.wdog_period_select;
        end
    end

    wdsw_timer #(
        .TICK_CYC (TICK_CYC),
        .MS_W     (MW)
    ) u_timer (
        .clk_sys  (clk_sys),
        .reset_n  (reset_n),
        .run      (ctrl_reg.wdog_enable_bit),
        .restart  (kick),
        .limit_ms (limit_ms),
        .expire   (expire)
    );

    // Access decode; a request takes effect in the cycle waitrequest is low
    assign req     = avs_read || avs_write;
    assign acc     = req && !waitrequest_reg;
    assign wr      = acc && avs_write && avs_byteenable[0];
    assign wr_data = avs_writedata[7:0];
    assign wr_ctrl = wr && (avs_address == `WDSW_ADDR_CTRL);
    assign wr_opt  = wr && (avs_address == `WDSW_ADDR_OPTION);
    assign wr_sw   = wr && (avs_address == `WDSW_ADDR_SWITCH);
    assign wr_ctrl_val = wdsw_ctrl_s'(wr_data);

    // Bus answer: one wait cycle, read data captured while address is held
    always_comb begin
        waitrequest_next = !(req && waitrequest_reg);
        readdata_next    = readdata_reg;
        if (req && waitrequest_reg) begin
            case (avs_address)
                `WDSW_ADDR_SWITCH:   readdata_next = {28'h0000000, sw_q};
                `WDSW_ADDR_CTRL:     readdata_next = {24'h000000, ctrl_reg};
                `WDSW_ADDR_STAT:     readdata_next = {31'h00000000, flag_reg};
                `WDSW_ADDR_OPTION:   readdata_next = {24'h000000, `WDSW_OPTION_ID};
                `WDSW_ADDR_IRQ_STAT: readdata_next = {30'h00000000, irq_stat_reg};
                `WDSW_ADDR_IRQ_MASK: readdata_next = {30'h00000000, irq_mask_reg};
                default:             readdata_next = 32'h00000000;
            endcase
        end
    end

    // Bus registers
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            waitrequest_reg <= 1'b1;
            readdata_reg    <= 32'h00000000;
        end else begin
            waitrequest_reg <= waitrequest_next;
            readdata_reg    <= readdata_next;
        end
    end

    // Watchdog events; a pulse in progress swallows any new trigger
    assign idle      = (pulse_cnt_reg == '0);
    assign en_rise   = ctrl_reg.wdog_enable_bit && !en_prev_reg;
    assign kick      = wr_ctrl && wr_ctrl_val.wdog_kick_bit && ctrl_reg.wdog_enable_bit;
    assign refused   = wr_ctrl && ctrl_reg.wdog_lock_bit && ctrl_reg.wdog_enable_bit
                       && !wr_ctrl_val.wdog_enable_bit;
    assign fire      = idle && (expire || (en_rise && flag_reg));
    assign hw_key    = wr_opt && (wr_data == `WDSW_OPT_RESET_KEY);
    assign start_rst = (fire && ctrl_reg.wdog_action_select == WDSW_ACT_RESET) || (hw_key && idle);

    // Watchdog next state
    always_comb begin
        ctrl_next       = ctrl_reg;
        flag_next       = flag_reg;
        pulse_cnt_next  = idle ? pulse_cnt_reg : pulse_cnt_reg - PW'(1);
        pulse_kind_next = pulse_kind_reg;
        if (wr_ctrl) begin
            // Writes to the switch address never reach here: it is read-only
            ctrl_next.wdog_action_select = wr_ctrl_val.wdog_action_select;
            ctrl_next.wdog_period_select = wr_ctrl_val.wdog_period_select;
            if (wr_ctrl_val.wdog_lock_bit) begin
                ctrl_next.wdog_lock_bit = 1'b1;
            end
            if (!refused) begin
                ctrl_next.wdog_enable_bit = wr_ctrl_val.wdog_enable_bit;
            end
        end
        ctrl_next.wdog_kick_bit = 1'b0;
        ctrl_next.rsvd          = 1'b0;
        if (hw_key) begin
            flag_next = 1'b0;
        end
        if (fire) begin
            flag_next       = 1'b1;
            pulse_kind_next = ctrl_reg.wdog_action_select;
            pulse_cnt_next  = (ctrl_reg.wdog_action_select == WDSW_ACT_NMI) ? PW'(NMI_CYC) : PW'(RST_CYC);
        end else if (hw_key && idle) begin
            pulse_kind_next = WDSW_ACT_RESET;
            pulse_cnt_next  = PW'(RST_CYC);
        end
        // A system reset also returns the watchdog to disabled and unlocked
        if (start_rst) begin
            ctrl_next = wdsw_ctrl_s'(`WDSW_CTRL_RST);
        end
        sys_reset_next = (pulse_cnt_next != '0) && (pulse_kind_next == WDSW_ACT_RESET);
        nmi_next       = (pulse_cnt_next != '0) && (pulse_kind_next == WDSW_ACT_NMI);
    end

    // Flag survives the pulses it causes; only reset_n and the key clear it
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            ctrl_reg       <= wdsw_ctrl_s'(`WDSW_CTRL_RST);
            flag_reg       <= 1'b0;
            en_prev_reg    <= 1'b0;
            pulse_cnt_reg  <= '0;
            pulse_kind_reg <= WDSW_ACT_RESET;
            sys_reset_reg  <= 1'b0;
            nmi_reg        <= 1'b0;
        end else begin
            ctrl_reg       <= ctrl_next;
            flag_reg       <= flag_next;
            en_prev_reg    <= ctrl_reg.wdog_enable_bit;
            pulse_cnt_reg  <= pulse_cnt_next;
            pulse_kind_reg <= pulse_kind_next;
            sys_reset_reg  <= sys_reset_next;
            nmi_reg        <= nmi_next;
        end
    end

    // Interrupt status: write one to clear, a new event wins over the clear
    always_comb begin
        irq_stat_next = irq_stat_reg;
        irq_mask_next = irq_mask_reg;
        if (wr && avs_address == `WDSW_ADDR_IRQ_STAT) begin
            irq_stat_next = irq_stat_reg & ~wdsw_irq_s'(wr_data[1:0]);
        end
        if (wr && avs_address == `WDSW_ADDR_IRQ_MASK) begin
            irq_mask_next = wdsw_irq_s'(wr_data[1:0]);
        end
        if (fire) begin
            irq_stat_next.expired = 1'b1;
        end
        if (refused) begin
            irq_stat_next.lock_refused = 1'b1;
        end
        irq_next = |(irq_stat_next & irq_mask_next);
    end

    // Interrupt registers
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            irq_stat_reg <= wdsw_irq_s'(`WDSW_IRQ_RST);
            irq_mask_reg <= wdsw_irq_s'(`WDSW_IRQ_RST);
            irq_reg      <= 1'b0;
        end else begin
            irq_stat_reg <= irq_stat_next;
            irq_mask_reg <= irq_mask_next;
            irq_reg      <= irq_next;
        end
    end

    assign avs_readdata    = readdata_reg;
    assign avs_waitrequest = waitrequest_reg;
    assign sys_reset_out   = sys_reset_reg;
    assign nmi_out         = nmi_reg;
    assign irq             = irq_reg;

    a_sw_live_value: assert property (@(posedge clk_sys) disable iff (!reset_n)
        acc && avs_read && avs_address == `WDSW_ADDR_SWITCH |-> avs_readdata[3:0] == $past(sw_q))
        else $error("switch read does not show synchronised switches");
    a_sw_upper_zero: assert property (@(posedge clk_sys) disable iff (!reset_n)
        acc && avs_read && avs_address == `WDSW_ADDR_SWITCH |-> avs_readdata[31:4] == 28'h0000000)
        else $error("switch read upper bits not zero");
    a_sw_write_none: assert property (@(posedge clk_sys) disable iff (!reset_n)
        wr_sw && idle && !expire |=> ctrl_reg == $past(ctrl_reg) && flag_reg == $past(flag_reg))
        else $error("write to switch register changed state");
    a_wd_off_reset: assert property (@(posedge clk_sys)
        !reset_n ##1 (reset_n && !wr_ctrl) |=> !ctrl_reg.wdog_enable_bit)
        else $error("watchdog enabled without software write");
    a_wd_reset_fire: assert property (@(posedge clk_sys) disable iff (!reset_n)
        expire && idle && ctrl_reg.wdog_action_select == WDSW_ACT_RESET |=> sys_reset_out [*8])
        else $error("expiry in reset mode gave no reset pulse");
    a_wd_flag_set: assert property (@(posedge clk_sys) disable iff (!reset_n)
        fire |=> flag_reg && !ctrl_reg.wdog_kick_bit)
        else $error("expiry did not set the flag");
    a_opt_key_clear: assert property (@(posedge clk_sys) disable iff (!reset_n)
        hw_key && idle && !fire |=> !flag_reg && sys_reset_out && !ctrl_reg.wdog_enable_bit)
        else $error("key write did not reset and clear flag");
    a_retrig_reset: assert property (@(posedge clk_sys) disable iff (!reset_n)
        en_rise && flag_reg && idle && ctrl_reg.wdog_action_select == WDSW_ACT_RESET |=> sys_reset_out)
        else $error("enable with flag set did not reset again");
    a_nmi_pulse_len: assert property (@(posedge clk_sys) disable iff (!reset_n)
        expire && idle && ctrl_reg.wdog_action_select == WDSW_ACT_NMI |=> nmi_out [*5] ##1 !nmi_out)
        else $error("expiry in NMI mode gave wrong NMI pulse");
    a_retrig_nmi: assert property (@(posedge clk_sys) disable iff (!reset_n)
        en_rise && flag_reg && idle && ctrl_reg.wdog_action_select == WDSW_ACT_NMI |=> nmi_out && !sys_reset_out)
        else $error("enable with flag set did not raise NMI again");
    a_period_short: assert property (@(posedge clk_sys) disable iff (!reset_n)
        ctrl_reg.wdog_period_select == 3'h0 && sw_q[0] |-> limit_ms == MW'(`WDSW_TO_SHORT_MS))
        else $error("odd switch with select 0 is not 100 ms");
    a_lock_hold: assert property (@(posedge clk_sys) disable iff (!reset_n)
        ctrl_reg.wdog_lock_bit && ctrl_reg.wdog_enable_bit |=> ctrl_reg.wdog_enable_bit || sys_reset_out)
        else $error("locked watchdog was disabled");
    a_kick_restart: assert property (@(posedge clk_sys) disable iff (!reset_n)
        kick |=> !expire ##1 !expire)
        else $error("kick did not restart the count");
endmodule

// [verilog/wdsw_defs.svh]
// Constants of the watchdog and switch input block
`ifndef WDSW_DEFS_SVH
`define WDSW_DEFS_SVH
`define WDSW_CLK_HZ 25000000
`define WDSW_CLK_PERIOD_NS (1000000000 / `WDSW_CLK_HZ)
`define WDSW_TICK_MS 1
`define WDSW_TICK_CYC (`WDSW_CLK_HZ / 1000 * `WDSW_TICK_MS)
`define WDSW_RST_PULSE_NS 1000
`define WDSW_RST_CYC ((`WDSW_RST_PULSE_NS + `WDSW_CLK_PERIOD_NS - 1) / `WDSW_CLK_PERIOD_NS)
`define WDSW_NMI_PULSE_NS 200
`define WDSW_NMI_CYC ((`WDSW_NMI_PULSE_NS + `WDSW_CLK_PERIOD_NS - 1) / `WDSW_CLK_PERIOD_NS)
`define WDSW_PULSE_W 5
`define WDSW_MS_W 18
`define WDSW_TO_SHORT_MS 100
`define WDSW_TO_BASE_MS 1000
`define WDSW_TO_STEP_MS 2000
`define WDSW_ADDR_W 16
`define WDSW_ADDR_SWITCH 16'h820c
`define WDSW_ADDR_CTRL 16'h8210
`define WDSW_ADDR_STAT 16'h8214
`define WDSW_ADDR_OPTION 16'h8218
`define WDSW_ADDR_IRQ_STAT 16'h821c
`define WDSW_ADDR_IRQ_MASK 16'h8220
`define WDSW_OPT_RESET_KEY 8'ha5
`define WDSW_OPTION_ID 8'h3c
`define WDSW_CTRL_RST 8'h00
`define WDSW_IRQ_RST 2'h0
`define WDSW_SW_W 4
`endif

// [verilog/wdsw_pkg.sv]
// Types shared by the watchdog and switch input block
package wdsw_pkg;
    typedef enum logic {
        WDSW_ACT_RESET = 1'b0,
        WDSW_ACT_NMI   = 1'b1
    } wdsw_action_e;

    typedef struct packed {
        logic         rsvd;
        logic [2:0]   wdog_period_select;
        logic         wdog_lock_bit;
        logic         wdog_kick_bit;
        wdsw_action_e wdog_action_select;
        logic         wdog_enable_bit;
    } wdsw_ctrl_s;

    typedef struct packed {
        logic lock_refused;
        logic expired;
    } wdsw_irq_s;
endpackage

// [verilog/wdsw_sync.sv]
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ns
module wdsw_sync #(
    parameter int W = 4
) (
    input  wire logic         clk_sys,
    input  wire logic         reset_n,
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);
    logic [W-1:0] ff1_reg;
    logic [W-1:0] ff2_reg;
    logic [W-1:0] ff3_reg;
    logic [W-1:0] out_reg;
    logic [W-1:0] out_next;

    if (W < 1) begin : g_chk
        $error("wdsw_sync: W must be at least 1");
    end

    // Take a new value only once the two late stages agree
    always_comb begin
        out_next = (ff2_reg == ff3_reg) ? ff3_reg : out_reg;
    end

    // Stages clear to zero; the switches settle within four edges anyway
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            ff1_reg <= '0;
            ff2_reg <= '0;
            ff3_reg <= '0;
            out_reg <= '0;
        end else begin
            ff1_reg <= din;
            ff2_reg <= ff1_reg;
            ff3_reg <= ff2_reg;
            out_reg <= out_next;
        end
    end

    assign dout = out_reg;
endmodule

// [verilog/wdsw_timer.sv]
// Millisecond timeout counter of the watchdog
`timescale 1ns/1ns
`include "wdsw_defs.svh"
module wdsw_timer #(
    parameter int TICK_CYC = `WDSW_TICK_CYC,
    parameter int MS_W     = `WDSW_MS_W
) (
    input  wire logic            clk_sys,
    input  wire logic            reset_n,
    input  wire logic            run,
    input  wire logic            restart,
    input  wire logic [MS_W-1:0] limit_ms,
    output logic                 expire
);
    localparam int TW = (TICK_CYC > 1) ? $clog2(TICK_CYC) : 1;

    logic [TW-1:0]   tick_reg;
    logic [TW-1:0]   tick_next;
    logic [MS_W-1:0] ms_reg;
    logic [MS_W-1:0] ms_next;
    logic            expire_reg;
    logic            expire_next;

    if (TICK_CYC < 1 || MS_W < 1) begin : g_chk
        $error("wdsw_timer: TICK_CYC and MS_W must be at least 1");
    end

    // Prescale to milliseconds so that 256 s needs only an 18-bit count
    always_comb begin
        tick_next   = tick_reg;
        ms_next     = ms_reg;
        expire_next = 1'b0;
        if (!run || restart) begin
            tick_next = '0;
            ms_next   = '0;
        end else if (tick_reg == TW'(TICK_CYC - 1)) begin
            tick_next = '0;
            // A limit lowered mid-count still expires, at the next millisecond tick
            if (ms_reg >= limit_ms - MS_W'(1)) begin
                ms_next     = '0;
                expire_next = 1'b1;
            end else begin
                ms_next = ms_reg + MS_W'(1);
            end
        end else begin
            tick_next = tick_reg + TW'(1);
        end
    end

    // Counter registers
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            tick_reg   <= '0;
            ms_reg     <= '0;
            expire_reg <= 1'b0;
        end else begin
            tick_reg   <= tick_next;
            ms_reg     <= ms_next;
            expire_reg <= expire_next;
        end
    end

    assign expire = expire_reg;
endmodule

// [verif/wdsw_top_tb.sv]
// Self-checking testbench of the watchdog and switch input block
`timescale 1ns/1ns
`include "wdsw_defs.svh"
module wdsw_top_tb;
    import wdsw_pkg::*;
    // Short millisecond tick keeps the longest period tested at a few thousand cycles
    localparam int TICK = 2;
    localparam int RSTC = `WDSW_RST_CYC;
    localparam int NMIC = `WDSW_NMI_CYC;
    logic                    clk_sys         = 1'b0;
    logic                    reset_n         = 1'b0;
    logic [`WDSW_ADDR_W-1:0] avs_address     = '0;
    logic                    avs_read        = 1'b0;
    logic                    avs_write       = 1'b0;
    logic [31:0]             avs_writedata   = 32'h0;
    logic [3:0]              avs_byteenable  = 4'h1;
    logic [31:0]             avs_readdata;
    logic                    avs_waitrequest;
    logic [`WDSW_SW_W-1:0]   config_switch   = 4'ha;
    logic                    sys_reset_out;
    logic                    nmi_out;
    logic                    irq;
    int                      n_errors        = 0;
    int                      n_checks        = 0;

    wdsw_top #(.TICK_CYC(TICK), .RST_CYC(RSTC), .NMI_CYC(NMIC)) dut_u (
        .clk_sys         (clk_sys),
        .reset_n         (reset_n),
        .avs_address     (avs_address),
        .avs_read        (avs_read),
        .avs_write       (avs_write),
        .avs_writedata   (avs_writedata),
        .avs_byteenable  (avs_byteenable),
        .avs_readdata    (avs_readdata),
        .avs_waitrequest (avs_waitrequest),
        .config_switch   (config_switch),
        .sys_reset_out   (sys_reset_out),
        .nmi_out         (nmi_out),
        .irq             (irq)
    );

    // 25 MHz system clock
    always #20 clk_sys = ~clk_sys;

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask

    // One Avalon access; request held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [15:0] a, input logic [7:0] d, output logic [31:0] q);
        int n;
        @(posedge clk_sys);
        avs_address <= a;
        avs_write <= wr;
        avs_read <= ~wr;
        avs_writedata <= {24'h0, d};
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 20);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        if (n >= 20) check("bus answer", 32'h0, 32'h1);
    endtask

    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask

    task automatic rd_chk(input string what, input logic [15:0] a, input logic [7:0] exp);
        logic [31:0] q;
        bus(1'b0, a, 8'h00, q);
        check(what, q, {24'h0, exp});
    endtask

    // Cycles until a pulse output rises (n), then how long it stays high (w)
    task automatic wait_out(input bit nmi, input int maxc, output int n, output int w);
        n = 0;
        w = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while ((nmi ? nmi_out : sys_reset_out) !== 1'b1 && n < maxc);
        while ((nmi ? nmi_out : sys_reset_out) === 1'b1 && w < 100) begin
            @(posedge clk_sys);
            w++;
        end
    endtask

    function automatic wdsw_ctrl_s mk(input logic [2:0] sel, input wdsw_action_e act, input logic lock);
        wdsw_ctrl_s c;
        c = '0;
        c.wdog_enable_bit = 1'b1;
        c.wdog_action_select = act;
        c.wdog_lock_bit = lock;
        c.wdog_period_select = sel;
        return c;
    endfunction

    // Enable, kick after 150 cycles, then expect expiry one full period after the kick
    task automatic run(input wdsw_ctrl_s c, input bit nmi, input int ms);
        int n;
        int w;
        c.wdog_enable_bit = 1'b0;
        wr(`WDSW_ADDR_CTRL, c);
        c.wdog_enable_bit = 1'b1;
        wr(`WDSW_ADDR_CTRL, c);
        repeat (150) @(posedge clk_sys);
        c.wdog_kick_bit = 1'b1;
        wr(`WDSW_ADDR_CTRL, c);
        wait_out(nmi, ms * TICK + 20, n, w);
        check("expiry delay in window", (n >= ms * TICK - 2 && n <= ms * TICK + 6), 32'h1);
        check("pulse width", w, nmi ? NMIC : RSTC);
    endtask

    // Key write: reset pulse, then the flag reads clear
    task automatic key_clear();
        int n;
        int w;
        wr(`WDSW_ADDR_OPTION, `WDSW_OPT_RESET_KEY);
        wait_out(1'b0, 10, n, w);
        check("key reset pulse", w, RSTC);
        rd_chk("flag after key", `WDSW_ADDR_STAT, 8'h00);
    endtask

    task automatic t_regs();
        repeat (6) @(posedge clk_sys);
        rd_chk("switch reg", `WDSW_ADDR_SWITCH, 8'h0a);
        wr(`WDSW_ADDR_SWITCH, 8'hff);
        rd_chk("switch after write", `WDSW_ADDR_SWITCH, 8'h0a);
        // A write without byte lane 0 must not reach the control register
        avs_byteenable <= 4'h0;
        wr(`WDSW_ADDR_CTRL, 8'h01);
        avs_byteenable <= 4'h1;
        config_switch <= 4'h5;
        repeat (6) @(posedge clk_sys);
        rd_chk("switch live", `WDSW_ADDR_SWITCH, 8'h05);
        rd_chk("ctrl at reset", `WDSW_ADDR_CTRL, 8'h00);
        rd_chk("flag at reset", `WDSW_ADDR_STAT, 8'h00);
        rd_chk("option id", `WDSW_ADDR_OPTION, `WDSW_OPTION_ID);
        rd_chk("unmapped", 16'h8300, 8'h00);
        check("no reset out idle", sys_reset_out, 1'b0);
    endtask

    task automatic t_reset_mode();
        int n;
        int w;
        config_switch <= 4'h1;
        repeat (6) @(posedge clk_sys);
        run(mk(3'h0, WDSW_ACT_RESET, 1'b0), 1'b0, `WDSW_TO_SHORT_MS);
        rd_chk("flag after expiry", `WDSW_ADDR_STAT, 8'h01);
        rd_chk("ctrl after reset", `WDSW_ADDR_CTRL, 8'h00);
        wr(`WDSW_ADDR_CTRL, mk(3'h0, WDSW_ACT_RESET, 1'b0));
        wait_out(1'b0, 6, n, w);
        check("refire on enable", n < 6, 32'h1);
        key_clear();
        config_switch <= 4'h0;
        repeat (6) @(posedge clk_sys);
        run(mk(3'h0, WDSW_ACT_RESET, 1'b0), 1'b0, `WDSW_TO_BASE_MS);
        key_clear();
    endtask

    task automatic t_nmi();
        int n;
        int w;
        config_switch <= 4'h1;
        wr(`WDSW_ADDR_IRQ_STAT, 8'h03);
        wr(`WDSW_ADDR_IRQ_MASK, 8'h03);
        check("irq idle", irq, 1'b0);
        run(mk(3'h1, WDSW_ACT_NMI, 1'b0), 1'b1, `WDSW_TO_STEP_MS * 2);
        rd_chk("flag after nmi", `WDSW_ADDR_STAT, 8'h01);
        check("irq on expiry", irq, 1'b1);
        wr(`WDSW_ADDR_CTRL, 8'h00);
        wr(`WDSW_ADDR_IRQ_STAT, 8'h01);
        repeat (2) @(posedge clk_sys);
        check("irq cleared", irq, 1'b0);
        wr(`WDSW_ADDR_CTRL, mk(3'h1, WDSW_ACT_NMI, 1'b0));
        wait_out(1'b1, 6, n, w);
        check("nmi again on enable", n < 6, 32'h1);
        wr(`WDSW_ADDR_CTRL, 8'h00);
        key_clear();
    endtask

    task automatic t_lock();
        int n;
        int w;
        wr(`WDSW_ADDR_IRQ_STAT, 8'h03);
        wr(`WDSW_ADDR_CTRL, mk(3'h0, WDSW_ACT_RESET, 1'b1));
        rd_chk("lock reads set", `WDSW_ADDR_CTRL, 8'h09);
        wr(`WDSW_ADDR_CTRL, 8'h00);
        rd_chk("disable refused", `WDSW_ADDR_CTRL, 8'h09);
        rd_chk("lock refused event", `WDSW_ADDR_IRQ_STAT, 8'h02);
        check("irq on refusal", irq, 1'b1);
        wait_out(1'b0, 300, n, w);
        check("locked dog expires", w, RSTC);
        rd_chk("flag locked", `WDSW_ADDR_STAT, 8'h01);
        key_clear();
        rd_chk("unlocked after pulse", `WDSW_ADDR_CTRL, 8'h00);
    endtask

    // Mid-run reset of a locked, running watchdog leaves it disabled and unlocked
    task automatic t_rst();
        wr(`WDSW_ADDR_CTRL, mk(3'h1, WDSW_ACT_NMI, 1'b1));
        reset_n <= 1'b0;
        repeat (3) @(posedge clk_sys);
        reset_n <= 1'b1;
        rd_chk("ctrl after reset_n", `WDSW_ADDR_CTRL, 8'h00);
        rd_chk("flag after reset_n", `WDSW_ADDR_STAT, 8'h00);
    endtask

    task automatic summarize();
        $display("checks %0d, errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // Main sequence
    initial begin
        repeat (20) @(posedge clk_sys);
        reset_n <= 1'b1;
        t_regs();
        t_reset_mode();
        t_nmi();
        t_lock();
        t_rst();
        summarize();
    end

    // Watchdog of the bench; the tests need about 12000 cycles
    initial begin
        repeat (40000) @(posedge clk_sys);
        n_errors++;
        $display("unexpected run time: expected end before 40000 cycles, seen none");
        summarize();
    end
endmodule
